// File: gate_seq_pkg.sv
package gate_seq_pkg;

   localparam int CLK_PERIOD_NS = 10;
   localparam int BLANK_NS = 20;
   localparam int ZERO_CUR_NS = 35;
   // least times round up to whole cycles
   localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ZERO_CUR_CYC = (ZERO_CUR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 3;

   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_MASK = 8'h08;
   localparam logic [7:0] ADDR_STATE = 8'h0C;

   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_PHASE_LSB = 2;
   localparam logic [1:0] CTRL_PHASE_RST = 2'h3;

   localparam int EV_SHUTDOWN = 0;
   localparam int EV_START = 1;
   localparam int EV_PG_RISE = 2;
   localparam int EV_PG_FALL = 3;
   localparam int EV_W = 4;

   localparam logic [4:0] NO_LOAD_CODE = 5'h1F;

   typedef enum logic [1:0] {
      MODE_EXT_A = 2'h0,
      MODE_EXT_B = 2'h1,
      MODE_ALT6 = 2'h2,
      MODE_ALT5 = 2'h3
   } dac_mode_t;

   typedef enum logic [4:0] {
      G_OFF = 5'h01,
      G_LOW_ON = 5'h02,
      G_LOW_FALL = 5'h04,
      G_HIGH_ON = 5'h08,
      G_HIGH_FALL = 5'h10
   } gate_state_t;

   typedef struct packed {
      logic [1:0] phases;
      dac_mode_t mode;
   } ctrl_t;

   typedef struct packed {
      logic node_window;
      logic lg_below_half;
      logic lg_below_175;
      logic ug_near_node;
      logic node_below_08;
      logic vcc_rise;
      logic vcc_fall;
      logic en_rise;
      logic en_fall;
      logic ph4_ok;
      logic gs1;
      logic gs2;
      logic gs3;
   } cmp_t;

   typedef struct packed {
      cmp_t sync1;
      cmp_t sync2;
      gate_state_t gst;
      logic [CNT_W-1:0] blank_cnt;
      logic [CNT_W-1:0] zc_cnt;
      logic scheme_lg;
      logic vcc_ok;
      logic en_ok;
      logic run;
      logic pg;
      ctrl_t ctrl;
      logic [EV_W-1:0] status;
      logic [EV_W-1:0] mask;
      logic ug;
      logic lg;
      logic autozero;
      logic pwm4;
      logic pwm4_oe;
      logic irq;
      logic [31:0] rdata;
   } state_t;

endpackage

// File: gate_deadtime_and_enable_sequencer.sv
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps

// How it works
// R1 - grounded select picks switch-node detect
// R2 - pulled-up select picks lower-gate detect
// R3 - node window reached releases upper gate
// R4 - zero current: release 35ns after lower low
// R5 - ignore node comparator 20ns after lower falls
// R6 - auto-zero tracks on-drop while lower conducts
// R7 - lower released on upper-near-node or node low
// R8 - lower-gate mode: release at 1.75V lower gate
// R9 - shutdown floats pulse outputs, gates off
// R10 - logic supply hysteretic power-on reset
// R11 - enable comparison with hysteresis
// R12 - fourth-channel enable required to start
// R13 - first gate supply; more phases need all
// R14 - other modes start soft-start at once
// R15 - 5-bit mode code 11111 blocks start
// R16 - power good after soft-start and in window
// R17 - power good low in shutdown and start
// R18 - comparators synchronised, delays rounded up
module gate_deadtime_and_enable_sequencer (
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   output logic IRQ_O,
   input wire logic PULSE_I,
   input wire logic PULSE_FOURTH_I,
   input wire logic DETECT_SCHEME_SELECT_I,
   input wire logic NODE_IN_WINDOW_I,
   input wire logic LOWER_GATE_BELOW_HALF_I,
   input wire logic LOWER_GATE_BELOW_175_I,
   input wire logic UPPER_GATE_NEAR_NODE_I,
   input wire logic NODE_BELOW_08_I,
   input wire logic LOGIC_SUPPLY_ABOVE_RISE_I,
   input wire logic LOGIC_SUPPLY_BELOW_FALL_I,
   input wire logic ENABLE_ABOVE_RISE_I,
   input wire logic ENABLE_BELOW_FALL_I,
   input wire logic FOURTH_CHANNEL_ENABLE_I,
   input wire logic GATE_SUPPLY_FIRST_OK_I,
   input wire logic GATE_SUPPLY_SECOND_OK_I,
   input wire logic GATE_SUPPLY_THIRD_OK_I,
   input wire logic [7:0] VOLTAGE_ID_CODE_I,
   input wire logic SOFTSTART_DONE_I,
   input wire logic OUTPUT_IN_WINDOW_I,
   output logic UPPER_GATE_DRIVE_O,
   output logic LOWER_GATE_DRIVE_O,
   output logic AUTOZERO_TRACK_O,
   output logic PULSE_FOURTH_O,
   output logic PULSE_FOURTH_OE_O,
   output logic SOFTSTART_RUN_O,
   output logic POWER_GOOD_FLAG_O
);

   gate_seq_pkg::state_t st_r;
   gate_seq_pkg::state_t st_nxt;
   gate_seq_pkg::cmp_t cmp_in;
   gate_seq_pkg::cmp_t c;
   logic supplies_ok;
   logic no_load;
   logic blank_done;
   logic zc_done;
   logic release_up;
   logic [gate_seq_pkg::EV_W-1:0] ev;
   logic [gate_seq_pkg::EV_W-1:0] status_keep;

   function automatic logic [gate_seq_pkg::CNT_W-1:0] sat_inc(
      input logic [gate_seq_pkg::CNT_W-1:0] v);
      sat_inc = (&v) ? v : v + 3'h1;
   endfunction

   assign cmp_in = '{node_window: NODE_IN_WINDOW_I,
                     lg_below_half: LOWER_GATE_BELOW_HALF_I,
                     lg_below_175: LOWER_GATE_BELOW_175_I,
                     ug_near_node: UPPER_GATE_NEAR_NODE_I,
                     node_below_08: NODE_BELOW_08_I,
                     vcc_rise: LOGIC_SUPPLY_ABOVE_RISE_I,
                     vcc_fall: LOGIC_SUPPLY_BELOW_FALL_I,
                     en_rise: ENABLE_ABOVE_RISE_I,
                     en_fall: ENABLE_BELOW_FALL_I,
                     ph4_ok: FOURTH_CHANNEL_ENABLE_I,
                     gs1: GATE_SUPPLY_FIRST_OK_I,
                     gs2: GATE_SUPPLY_SECOND_OK_I,
                     gs3: GATE_SUPPLY_THIRD_OK_I};

   // only the second stage is ever looked at
   assign c = st_r.sync2;

   always_comb begin
      st_nxt = st_r;
      st_nxt.sync1 = cmp_in; // R18
      st_nxt.sync2 = st_r.sync1; // R18

      // hysteresis: set above the rising level, clear below the falling one
      if (c.vcc_rise) begin
         st_nxt.vcc_ok = 1'b1; // R10
      end else if (c.vcc_fall) begin
         st_nxt.vcc_ok = 1'b0; // R10
      end
      if (c.en_rise) begin
         st_nxt.en_ok = 1'b1; // R11
      end else if (c.en_fall) begin
         st_nxt.en_ok = 1'b0; // R11
      end

      // phase count 0 is read as single phase
      supplies_ok = c.gs1 & ((st_r.ctrl.phases <= 2'h1) | (c.gs2 & c.gs3)); // R13
      no_load = (st_r.ctrl.mode == gate_seq_pkg::MODE_ALT5) &&
                (VOLTAGE_ID_CODE_I[4:0] == gate_seq_pkg::NO_LOAD_CODE); // R15
      st_nxt.run = st_r.vcc_ok & st_r.en_ok & c.ph4_ok & supplies_ok & ~no_load; // R14 R12
      st_nxt.pg = st_nxt.run & st_r.run & SOFTSTART_DONE_I & OUTPUT_IN_WINDOW_I; // R16 R17

      blank_done = st_r.blank_cnt >= gate_seq_pkg::CNT_W'(gate_seq_pkg::BLANK_CYC);
      zc_done = st_r.zc_cnt >= gate_seq_pkg::CNT_W'(gate_seq_pkg::ZERO_CUR_CYC);
      if (st_r.scheme_lg) begin
         release_up = c.lg_below_175; // R8
      end else begin
         release_up = (blank_done & c.node_window) | zc_done; // R3 R4 R5
      end

      unique case (st_r.gst)
         gate_seq_pkg::G_OFF: begin
            st_nxt.ug = 1'b0;
            st_nxt.lg = 1'b0;
            if (st_r.run) begin
               // scheme is taken only when leaving shutdown
               st_nxt.scheme_lg = DETECT_SCHEME_SELECT_I; // R1 R2
               st_nxt.blank_cnt = '0;
               st_nxt.zc_cnt = '0;
               if (PULSE_I) begin
                  st_nxt.gst = gate_seq_pkg::G_LOW_FALL;
               end else begin
                  st_nxt.gst = gate_seq_pkg::G_LOW_ON;
                  st_nxt.lg = 1'b1;
               end
            end
         end
         gate_seq_pkg::G_LOW_ON: begin
            if (PULSE_I) begin
               st_nxt.lg = 1'b0;
               st_nxt.gst = gate_seq_pkg::G_LOW_FALL;
               st_nxt.blank_cnt = '0; // R5
               st_nxt.zc_cnt = '0;
            end
         end
         gate_seq_pkg::G_LOW_FALL: begin
            st_nxt.blank_cnt = sat_inc(st_r.blank_cnt); // R5
            st_nxt.zc_cnt = c.lg_below_half ? sat_inc(st_r.zc_cnt) : '0; // R4
            if (release_up) begin
               // a pulse already gone just turns the lower switch back on
               if (PULSE_I) begin
                  st_nxt.ug = 1'b1; // R3 R8
                  st_nxt.gst = gate_seq_pkg::G_HIGH_ON;
               end else begin
                  st_nxt.lg = 1'b1;
                  st_nxt.gst = gate_seq_pkg::G_LOW_ON;
               end
            end
         end
         gate_seq_pkg::G_HIGH_ON: begin
            if (!PULSE_I) begin
               st_nxt.ug = 1'b0;
               st_nxt.gst = gate_seq_pkg::G_HIGH_FALL;
            end
         end
         gate_seq_pkg::G_HIGH_FALL: begin
            if (c.ug_near_node | c.node_below_08) begin
               st_nxt.lg = 1'b1; // R7
               st_nxt.gst = gate_seq_pkg::G_LOW_ON;
            end
         end
      endcase

      if (!st_r.run) begin
         st_nxt.gst = gate_seq_pkg::G_OFF; // R9
         st_nxt.ug = 1'b0; // R9
         st_nxt.lg = 1'b0; // R9
      end
      // comparator tracks the on-drop only while the lower switch conducts
      st_nxt.autozero = (st_nxt.gst == gate_seq_pkg::G_LOW_ON); // R6
      st_nxt.pwm4 = st_r.run & PULSE_FOURTH_I; // R9
      st_nxt.pwm4_oe = st_r.run; // R9

      ev = '0;
      ev[gate_seq_pkg::EV_SHUTDOWN] = st_r.run & ~st_nxt.run;
      ev[gate_seq_pkg::EV_START] = ~st_r.run & st_nxt.run;
      ev[gate_seq_pkg::EV_PG_RISE] = ~st_r.pg & st_nxt.pg;
      ev[gate_seq_pkg::EV_PG_FALL] = st_r.pg & ~st_nxt.pg;

      st_nxt.rdata = '0;
      status_keep = st_r.status;
      if (RD_I) begin
         case (ADDR_I)
            gate_seq_pkg::ADDR_CTRL: begin
               st_nxt.rdata = {28'h0000000, st_r.ctrl};
            end
            gate_seq_pkg::ADDR_STATUS: begin
               st_nxt.rdata = {28'h0000000, st_r.status};
               status_keep = '0;
            end
            gate_seq_pkg::ADDR_MASK: begin
               st_nxt.rdata = {28'h0000000, st_r.mask};
            end
            gate_seq_pkg::ADDR_STATE: begin
               st_nxt.rdata = {24'h000000, st_r.gst, st_r.pg, st_r.run, st_r.scheme_lg};
            end
            default: begin
               st_nxt.rdata = '0;
            end
         endcase
      end
      // a new event beats the clear-on-read in the same cycle
      st_nxt.status = status_keep | ev;
      if (WR_I) begin
         if (ADDR_I == gate_seq_pkg::ADDR_CTRL) begin
            st_nxt.ctrl.mode = gate_seq_pkg::dac_mode_t'(WDATA_I[gate_seq_pkg::CTRL_MODE_LSB +: 2]);
            st_nxt.ctrl.phases = WDATA_I[gate_seq_pkg::CTRL_PHASE_LSB +: 2];
         end else if (ADDR_I == gate_seq_pkg::ADDR_MASK) begin
            st_nxt.mask = WDATA_I[gate_seq_pkg::EV_W-1:0];
         end
      end
      st_nxt.irq = |(st_nxt.status & st_nxt.mask);
   end

   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_r <= '0;
         st_r.gst <= gate_seq_pkg::G_OFF;
         st_r.ctrl.phases <= gate_seq_pkg::CTRL_PHASE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign RDATA_O = st_r.rdata;
   assign IRQ_O = st_r.irq;
   assign UPPER_GATE_DRIVE_O = st_r.ug;
   assign LOWER_GATE_DRIVE_O = st_r.lg;
   assign AUTOZERO_TRACK_O = st_r.autozero;
   assign PULSE_FOURTH_O = st_r.pwm4;
   assign PULSE_FOURTH_OE_O = st_r.pwm4_oe;
   assign SOFTSTART_RUN_O = st_r.run;
   assign POWER_GOOD_FLAG_O = st_r.pg;

   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (!RST_N_I);

   no_overlap_a: assert property (!(UPPER_GATE_DRIVE_O && LOWER_GATE_DRIVE_O)) // R7
      else $error("both gate drives on");
   scheme_latch_a: assert property ((st_r.gst == gate_seq_pkg::G_OFF && st_r.run) // R1
      |=> st_r.scheme_lg == $past(DETECT_SCHEME_SELECT_I))
      else $error("detect scheme not taken at start");
   node_window_a: assert property ((st_r.gst == gate_seq_pkg::G_LOW_FALL && !st_r.scheme_lg // R3
      && blank_done && c.node_window && PULSE_I && st_r.run) |=> UPPER_GATE_DRIVE_O)
      else $error("upper not released on node window");
   zero_current_a: assert property ((st_r.gst == gate_seq_pkg::G_LOW_FALL && !st_r.scheme_lg // R4
      && c.lg_below_half && PULSE_I && st_r.run)[*5] |=> UPPER_GATE_DRIVE_O)
      else $error("zero current release late");
   blanking_a: assert property ((st_r.gst == gate_seq_pkg::G_LOW_FALL && !st_r.scheme_lg // R5
      && !blank_done && !zc_done) |=> !UPPER_GATE_DRIVE_O)
      else $error("upper released inside blanking");
   autozero_a: assert property (AUTOZERO_TRACK_O == (st_r.gst == gate_seq_pkg::G_LOW_ON)) // R6
      else $error("auto-zero not tracking lower conduction");
   lower_release_a: assert property ((st_r.gst == gate_seq_pkg::G_HIGH_FALL && st_r.run // R7
      && (c.ug_near_node || c.node_below_08)) |=> LOWER_GATE_DRIVE_O)
      else $error("lower gate not released");
   lower_gate_drive_scheme_a: assert property ((st_r.gst == gate_seq_pkg::G_LOW_FALL && st_r.scheme_lg // R8
      && c.lg_below_175 && PULSE_I && st_r.run) |=> UPPER_GATE_DRIVE_O)
      else $error("upper not released in lower-gate scheme");
   shutdown_float_a: assert property (!SOFTSTART_RUN_O |=> // R9
      (!PULSE_FOURTH_OE_O && !UPPER_GATE_DRIVE_O && !LOWER_GATE_DRIVE_O))
      else $error("outputs active in shutdown");
   supply_hyst_a: assert property ((st_r.vcc_ok && !c.vcc_fall) |=> st_r.vcc_ok) // R10
      else $error("logic supply dropped without falling trip");
   enable_hyst_a: assert property ((st_r.en_ok && !c.en_fall) |=> st_r.en_ok) // R11
      else $error("enable dropped without falling trip");
   fourth_enable_a: assert property (!c.ph4_ok |=> !SOFTSTART_RUN_O) // R12
      else $error("started without fourth channel enable");
   first_supply_a: assert property (!c.gs1 |=> !SOFTSTART_RUN_O) // R13
      else $error("started without first gate supply");
   start_now_a: assert property ((st_r.vcc_ok && st_r.en_ok && c.ph4_ok && c.gs1 && c.gs2 // R14
      && c.gs3 && st_r.ctrl.mode != gate_seq_pkg::MODE_ALT5) |=> SOFTSTART_RUN_O)
      else $error("soft-start not begun at once");
   no_load_a: assert property ((st_r.ctrl.mode == gate_seq_pkg::MODE_ALT5 // R15
      && VOLTAGE_ID_CODE_I[4:0] == gate_seq_pkg::NO_LOAD_CODE) |=> !SOFTSTART_RUN_O)
      else $error("started on no-load code");
   pg_cause_a: assert property ($rose(POWER_GOOD_FLAG_O) |-> // R16
      $past(SOFTSTART_DONE_I && OUTPUT_IN_WINDOW_I))
      else $error("power good without done and window");
   pg_run_a: assert property (POWER_GOOD_FLAG_O |-> SOFTSTART_RUN_O) // R17
      else $error("power good during shutdown");
   // the pipe still holds reset zeros for two edges after release
   sync_depth_a: assert property ($past(RST_N_I, 2) // R18
      |-> st_r.sync2 == $past(cmp_in, 2))
      else $error("comparator sync depth wrong");
   irq_level_a: assert property (IRQ_O == |(st_r.status & st_r.mask))
      else $error("interrupt level mismatch");

   // read data lives one cycle; status stays until a status read
   rdata_idle_a: assert property (!$past(RD_I)
      |-> RDATA_O == 32'h00000000)
      else $error("read data not zero outside a read");
   status_read_a: assert property ((RD_I && ADDR_I == gate_seq_pkg::ADDR_STATUS)
      |=> RDATA_O[gate_seq_pkg::EV_W-1:0] == $past(st_r.status))
      else $error("status read returned wrong bits");
   read_clear_a: assert property ((RD_I && ADDR_I == gate_seq_pkg::ADDR_STATUS)
      |=> st_r.status == $past(ev))
      else $error("status not cleared by read");
   status_sticky_a: assert property (!(RD_I && ADDR_I == gate_seq_pkg::ADDR_STATUS)
      |=> (st_r.status & $past(st_r.status)) == $past(st_r.status))
      else $error("status bit lost without a read");
   mask_write_a: assert property ((WR_I && ADDR_I == gate_seq_pkg::ADDR_MASK)
      |=> st_r.mask == $past(WDATA_I[gate_seq_pkg::EV_W-1:0]))
      else $error("mask write not taken");
   ctrl_write_a: assert property ((WR_I && ADDR_I == gate_seq_pkg::ADDR_CTRL)
      |=> st_r.ctrl == $past(WDATA_I[3:0]))
      else $error("control write not taken");

   start_event_a: assert property ($rose(SOFTSTART_RUN_O)
      |-> st_r.status[gate_seq_pkg::EV_START])
      else $error("start event not recorded");
   stop_event_a: assert property ($fell(SOFTSTART_RUN_O)
      |-> st_r.status[gate_seq_pkg::EV_SHUTDOWN])
      else $error("shutdown event not recorded");
   pg_rise_ev_a: assert property ($rose(POWER_GOOD_FLAG_O)
      |-> st_r.status[gate_seq_pkg::EV_PG_RISE])
      else $error("power good rise not recorded");
   pg_fall_ev_a: assert property ($fell(POWER_GOOD_FLAG_O)
      |-> st_r.status[gate_seq_pkg::EV_PG_FALL])
      else $error("power good fall not recorded");

   lower_off_a: assert property ((st_r.gst == gate_seq_pkg::G_LOW_ON && PULSE_I && st_r.run)
      |=> !LOWER_GATE_DRIVE_O)
      else $error("lower gate kept on after pulse rise");
   upper_off_a: assert property ((st_r.gst == gate_seq_pkg::G_HIGH_ON && !PULSE_I) // R7
      |=> !UPPER_GATE_DRIVE_O)
      else $error("upper gate kept on after pulse fall");
   state_onehot_a: assert property (st_r.run
      |-> $onehot(st_r.gst))
      else $error("gate state not one-hot");
   off_state_a: assert property ((st_r.gst == gate_seq_pkg::G_OFF) // R9
      |-> (!UPPER_GATE_DRIVE_O && !LOWER_GATE_DRIVE_O))
      else $error("gate driven in off state");
   fourth_pulse_a: assert property (PULSE_FOURTH_O // R9
      |-> PULSE_FOURTH_OE_O)
      else $error("fourth pulse driven while floating");
   oe_follow_a: assert property (SOFTSTART_RUN_O // R9
      |=> PULSE_FOURTH_OE_O)
      else $error("fourth pulse not driven while running");

   supply_off_a: assert property (!st_r.vcc_ok // R10
      |=> !SOFTSTART_RUN_O)
      else $error("running without logic supply");
   enable_off_a: assert property (!st_r.en_ok // R11
      |=> !SOFTSTART_RUN_O)
      else $error("running without enable");
   phase_supply_a: assert property ((st_r.ctrl.phases > 2'h1 && !(c.gs2 && c.gs3)) // R13
      |=> !SOFTSTART_RUN_O)
      else $error("multiphase start without all gate supplies");
   pg_start_low_a: assert property ($rose(SOFTSTART_RUN_O) // R17
      |-> !POWER_GOOD_FLAG_O)
      else $error("power good high at start");

   upper_on_c: cover property ($rose(UPPER_GATE_DRIVE_O));
   zc_release_c: cover property (st_r.gst == gate_seq_pkg::G_LOW_FALL && zc_done);
   pg_rise_c: cover property ($rose(POWER_GOOD_FLAG_O));
   irq_c: cover property ($rose(IRQ_O));
   lg_release_c: cover property (st_r.gst == gate_seq_pkg::G_LOW_FALL && st_r.scheme_lg);

endmodule

// File: gate_partner_model.sv
`timescale 1ns/1ps
module gate_partner_model (
   input wire logic clk_i,
   input wire logic ug_i,
   input wire logic lg_i,
   input wire logic [1:0] d_i,
   input wire logic [1:0] e_i,
   input wire logic cur_i,
   input wire logic sel_i,
   output logic win_o,
   output logic half_o,
   output logic b175_o,
   output logic near_o,
   output logic b08_o
);
   // cycles since each drive dropped; the gate voltage decays over d_i or e_i cycles
   logic [3:0] lc_r = 4'h0;
   logic [3:0] uc_r = 4'h0;
   always_ff @(posedge clk_i) begin
      lc_r <= lg_i ? 4'h0 : (lc_r == 4'hF ? lc_r : lc_r + 4'h1);
      uc_r <= ug_i ? 4'h0 : (uc_r == 4'hF ? uc_r : uc_r + 4'h1);
   end
   // with no inductor current the node never enters the window
   assign win_o = cur_i && !ug_i && !lg_i && lc_r >= {2'h0, d_i};
   assign half_o = !lg_i && lc_r >= {2'h0, d_i};
   assign b175_o = !lg_i && lc_r >= {2'h0, d_i};
   assign near_o = !ug_i && !sel_i && uc_r >= {2'h0, e_i};
   assign b08_o = !ug_i && sel_i && uc_r >= {2'h0, e_i};
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00, voltage_id_code = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic pulse = 1'b0, pulse4 = 1'b0, sch = 1'b0, vh = 1'b0, vl = 1'b1, eh = 1'b0, el = 1'b1;
   logic ph4 = 1'b1, g1 = 1'b1, g2 = 1'b1, g3 = 1'b1, done = 1'b1, inwin = 1'b1;
   logic win, half, b175, near, b08, irq, ug, lg, az, p4o, p4oe, run, pg;
   logic [1:0] d = 2'h1, e = 2'h0, mode = 2'h0, ph = 2'h3;
   logic cur = 1'b0, sel = 1'b0, vok = 1'b0, eok = 1'b0, erun = 1'b0, epg = 1'b0;
   logic [3:0] est = 4'h0, msk;
   int errors = 0, cmp_count = 0;

   initial forever #5 clk = ~clk;

   gate_deadtime_and_enable_sequencer i_gate_deadtime_and_enable_sequencer (
      .CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
      .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .PULSE_I(pulse), .PULSE_FOURTH_I(pulse4),
      .DETECT_SCHEME_SELECT_I(sch), .NODE_IN_WINDOW_I(win), .LOWER_GATE_BELOW_HALF_I(half),
      .LOWER_GATE_BELOW_175_I(b175), .UPPER_GATE_NEAR_NODE_I(near), .NODE_BELOW_08_I(b08),
      .LOGIC_SUPPLY_ABOVE_RISE_I(vh), .LOGIC_SUPPLY_BELOW_FALL_I(vl),
      .ENABLE_ABOVE_RISE_I(eh), .ENABLE_BELOW_FALL_I(el), .FOURTH_CHANNEL_ENABLE_I(ph4),
      .GATE_SUPPLY_FIRST_OK_I(g1), .GATE_SUPPLY_SECOND_OK_I(g2),
      .GATE_SUPPLY_THIRD_OK_I(g3), .VOLTAGE_ID_CODE_I(voltage_id_code), .SOFTSTART_DONE_I(done),
      .OUTPUT_IN_WINDOW_I(inwin), .UPPER_GATE_DRIVE_O(ug), .LOWER_GATE_DRIVE_O(lg),
      .AUTOZERO_TRACK_O(az), .PULSE_FOURTH_O(p4o), .PULSE_FOURTH_OE_O(p4oe),
      .SOFTSTART_RUN_O(run), .POWER_GOOD_FLAG_O(pg)
   );

   gate_partner_model i_gate_partner_model (
      .clk_i(clk), .ug_i(ug), .lg_i(lg), .d_i(d), .e_i(e), .cur_i(cur), .sel_i(sel),
      .win_o(win), .half_o(half), .b175_o(b175), .near_o(near), .b08_o(b08)
   );

   task automatic end_sim();
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end
      else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(nm, rdata & m, exp);
   endtask

   function automatic logic f_run();
      return vok && eok && ph4 && g1 && (ph <= 2'h1 || (g2 && g3)) &&
             !(mode == 2'h3 && voltage_id_code[4:0] == 5'h1F);
   endfunction

   // time from a pulse edge to the opposite gate coming on, with overlap watched
   task automatic gate_edge(input logic lvl, input string nm, input int exp);
      int n;
      @(posedge clk);
      pulse <= lvl;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
         if (n == 1) chk("first gate off", lvl ? lg : ug, 1'b0);
         if (ug && lg) chk("overlap", 1'b1, 1'b0);
         chk("autozero", az, lg);
      end while ((lvl ? ug : lg) !== 1'b1 && n < 30);
      if (n >= 30) begin
         chk("timeout", 1'b1, 1'b0);
         return;
      end
      chk(nm, n, exp);
   endtask

   initial begin
      int seed, k, lv;
      logic b, nr, np;
      seed = $urandom(32'h5f963eb6);
      cyc(5);
      chk("reset outs", {irq, ug, lg, az, p4o, p4oe, run, pg}, 8'h00);
      chk("reset rdata", rdata, 32'h0);
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk("ctrl reset", gate_seq_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h0000000C);
      rd_chk("mask reset", gate_seq_pkg::ADDR_MASK, 32'hFFFFFFFF, 32'h0);
      rd_chk("status reset", gate_seq_pkg::ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
      rd_chk("unmapped", 8'h10, 32'hFFFFFFFF, 32'h0);
      $display("test reset done");
      // one condition changes per step so the run flag never passes through a transient
      repeat (80) begin
         k = $urandom % 8;
         lv = $urandom % 3;
         b = 1'($urandom);
         if (k == 7) begin
            mode = 2'($urandom);
            ph = 2'($urandom);
            wr_reg(gate_seq_pkg::ADDR_CTRL, {28'h0, ph, mode});
            rd_chk("ctrl", gate_seq_pkg::ADDR_CTRL, 32'hFFFFFFFF, {ph, mode});
         end
         @(posedge clk);
         pulse4 <= b;
         case (k)
            0: begin
               vh <= lv == 2;
               vl <= lv == 0;
            end
            1: begin
               eh <= lv == 2;
               el <= lv == 0;
            end
            2: ph4 <= lv != 0;
            3: g1 <= lv != 0;
            4: begin
               g2 <= b;
               g3 <= lv != 0;
            end
            5: voltage_id_code <= {3'($urandom), b ? 5'h1F : 5'($urandom)};
            6: begin
               done <= b;
               inwin <= lv != 0;
            end
            default: ;
         endcase
         if (k == 0 && lv != 1) vok = lv == 2;
         if (k == 1 && lv != 1) eok = lv == 2;
         cyc(6);
         nr = f_run();
         np = nr && done && inwin;
         est = est | {epg && !np, np && !epg, nr && !erun, erun && !nr};
         erun = nr;
         epg = np;
         chk("run", run, erun);
         chk("power good", pg, epg);
         chk("fourth oe", p4oe, erun);
         chk("fourth pulse", p4o, erun & pulse4);
         if (!erun) chk("gates off", {ug, lg}, 2'h0);
         msk = 4'($urandom);
         wr_reg(gate_seq_pkg::ADDR_MASK, {28'h0, msk});
         cyc(2);
         chk("irq", irq, |(est & msk));
         rd_chk("status", gate_seq_pkg::ADDR_STATUS, 32'hFFFFFFFF, {28'h0, est});
         est = 4'h0;
         cyc(2);
         chk("irq cleared", irq, 1'b0);
         rd_chk("state", gate_seq_pkg::ADDR_STATE, 32'h6, {epg, erun, 1'b0});
      end
      $display("test enable done");
      wr_reg(gate_seq_pkg::ADDR_CTRL, 32'h0000000C);
      @(posedge clk);
      {vh, vl, ph4, g1, g2, g3, voltage_id_code} <= {6'h2F, 8'h00};
      for (int c = 0; c < 3; c++) begin
         @(posedge clk);
         {eh, el} <= 2'b01;
         cyc(8);
         chk("shutdown gates", {ug, lg, p4oe}, 3'h0);
         @(posedge clk);
         sch <= c == 2;
         cur <= c == 0;
         {eh, el} <= 2'b10;
         cyc(8);
         rd_chk("scheme", gate_seq_pkg::ADDR_STATE, 32'h1, c == 2);
         repeat (4) begin
            @(posedge clk);
            d <= 2'(1 + $urandom % 3);
            e <= 2'($urandom % 3);
            sel <= 1'($urandom);
            cyc(4);
            gate_edge(1'b1, "upper release", (c == 1 ? 8 : 4) + int'(d));
            cyc(3);
            gate_edge(1'b0, "lower release", 4 + int'(e));
            cyc(3);
         end
      end
      $display("test gates done");
      end_sim();
   end
endmodule
